// File: dsr_host.sv
// Host end: frame sequencer that makes select and serial clock and reads results.
`timescale 1ns/1ns
`default_nettype none
module dsr_host
	import dsr_pkg::*;
#(
	parameter int HALF_CYC  = HALF_MIN_CYC,
	parameter int FRAME_CYC = FRAME_MIN_CYC
)
(
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst_b,
	input  wire logic                i_run,
	output logic                     o_busy,
	output logic [RES_BITS-1:0]      o_data,
	output logic                     o_data_valid,
	output logic                     o_null_err,
	dsr_link_if.host                 link
);

	// ****************************************************************
	// Timing limits.
	// ****************************************************************
	localparam int HALF_USE  = (HALF_CYC < HALF_MIN_CYC) ? HALF_MIN_CYC :
		((HALF_CYC > HALF_MAX_CYC) ? HALF_MAX_CYC : HALF_CYC);
	localparam int FRAME_LO  = (FRAME_MIN_CYC > (2 * FRAME_BITS + 1) * HALF_USE + CS_HIGH_CYC) ?
		FRAME_MIN_CYC : (2 * FRAME_BITS + 1) * HALF_USE + CS_HIGH_CYC;
	localparam int FRAME_USE = (FRAME_CYC < FRAME_LO) ? FRAME_LO :
		((FRAME_CYC > FRAME_MAX_CYC) ? FRAME_MAX_CYC : FRAME_CYC);
	localparam logic [TMR_W-1:0] HALF_END  = TMR_W'(HALF_USE - 1); // see R8
	localparam logic [TMR_W-1:0] FRAME_END = TMR_W'(FRAME_USE - 1); // see R9

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	dsr_state_e            state_ff;
	dsr_state_e            nxt_state;
	logic [TMR_W-1:0]      div_ff;
	logic [TMR_W-1:0]      nxt_div;
	logic [TMR_W-1:0]      period_ff;
	logic [TMR_W-1:0]      nxt_period;
	logic [CNT_W-1:0]      bit_ff;
	logic [CNT_W-1:0]      nxt_bit;
	logic [FRAME_BITS-1:0] shift_ff;
	logic [FRAME_BITS-1:0] nxt_shift;
	logic                  cs_b_ff;
	logic                  nxt_cs_b;
	logic                  sclk_ff;
	logic                  nxt_sclk;
	logic [RES_BITS-1:0]   data_ff;
	logic [RES_BITS-1:0]   nxt_data;
	logic                  valid_ff;
	logic                  nxt_valid;
	logic                  null_err_ff;
	logic                  nxt_null_err;
	logic                  din_meta_ff;
	logic                  din_sync_ff;
	logic                  div_done;

	assign div_done = (div_ff == HALF_END);

	// ****************************************************************
	// Frame sequencer.
	// ****************************************************************
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_div      = div_done ? '0 : div_ff + TMR_W'(1);
		nxt_period   = (period_ff == FRAME_END) ? period_ff : period_ff + TMR_W'(1);
		nxt_bit      = bit_ff;
		nxt_shift    = shift_ff;
		nxt_cs_b     = cs_b_ff;
		nxt_sclk     = sclk_ff;
		nxt_data     = data_ff;
		nxt_valid    = 1'b0;
		nxt_null_err = null_err_ff;
		case (state_ff)
			DSR_IDLE:
			begin
				nxt_div = '0;
				if (i_run)
				begin
					// Select falls and stays low through the whole frame.
					nxt_state  = DSR_SETUP;
					nxt_cs_b   = 1'b0; // see R3
					nxt_period = '0;
					nxt_bit    = '0;
				end
			end
			DSR_SETUP:
			begin
				if (div_done)
				begin
					nxt_state = DSR_LOW;
					nxt_sclk  = 1'b0; // see R7
				end
			end
			DSR_LOW:
			begin
				if (div_done)
				begin
					// Sampling at the end of the low half equals the rising edge.
					nxt_state = DSR_HIGH;
					nxt_sclk  = 1'b1;
					nxt_shift = {shift_ff[FRAME_BITS-2:0], din_sync_ff}; // see R6
				end
			end
			DSR_HIGH:
			begin
				if (div_done)
				begin
					if (bit_ff == FRAME_EDGES - 5'h01)
					begin
						nxt_state    = DSR_GAP;
						nxt_cs_b     = 1'b1;
						nxt_data     = shift_ff[RES_BITS-1:0];
						nxt_valid    = 1'b1;
						nxt_null_err = |shift_ff[FRAME_BITS-1:RES_BITS];
					end
					else
					begin
						nxt_state = DSR_LOW;
						nxt_sclk  = 1'b0;
						nxt_bit   = bit_ff + 5'h01;
					end
				end
			end
			DSR_GAP:
			begin
				nxt_div = '0;
				if (period_ff == FRAME_END)
				begin
					// Frame starts are spaced to hold the sample rate in range.
					nxt_state  = i_run ? DSR_SETUP : DSR_IDLE; // see R9
					nxt_cs_b   = ~i_run;
					nxt_period = '0;
					nxt_bit    = '0;
				end
			end
			default:
			begin
				nxt_state = DSR_IDLE;
				nxt_cs_b  = 1'b1;
				nxt_sclk  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			state_ff    <= DSR_IDLE;
			div_ff      <= '0;
			period_ff   <= '0;
			bit_ff      <= '0;
			shift_ff    <= '0;
			cs_b_ff     <= 1'b1;
			sclk_ff     <= 1'b1;
			data_ff     <= '0;
			valid_ff    <= 1'b0;
			null_err_ff <= 1'b0;
			din_meta_ff <= 1'b0;
			din_sync_ff <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			div_ff      <= nxt_div;
			period_ff   <= nxt_period;
			bit_ff      <= nxt_bit;
			shift_ff    <= nxt_shift;
			cs_b_ff     <= nxt_cs_b;
			sclk_ff     <= nxt_sclk;
			data_ff     <= nxt_data;
			valid_ff    <= nxt_valid;
			null_err_ff <= nxt_null_err;
			din_meta_ff <= link.dout_line;
			din_sync_ff <= din_meta_ff;
		end
	end

	assign link.cs_b    = cs_b_ff;
	assign link.sclk    = sclk_ff;
	assign o_busy       = ~cs_b_ff;
	assign o_data       = data_ff;
	assign o_data_valid = valid_ff;
	assign o_null_err   = null_err_ff;

endmodule : dsr_host
`default_nettype wire

// File: dsr_pkg.sv
// Shared constants for the serial converter readout, both ends.
package dsr_pkg;

	// ****************************************************************
	// Frame layout.
	// ****************************************************************
	localparam int          NULL_BITS      = 2;
	localparam int          RES_BITS       = 14;
	localparam int          FRAME_BITS     = NULL_BITS + RES_BITS;
	localparam int          CNT_W          = 5;
	localparam int          TMR_W          = 12;
	localparam logic [4:0]  FIRST_RES_EDGE = 5'h03;
	localparam logic [4:0]  LAST_RES_EDGE  = 5'h10;
	localparam logic [4:0]  FRAME_EDGES    = 5'h10;
	localparam logic [13:0] SIGN_MASK      = 14'h2000;
	localparam logic [13:0] ONE_LSB        = 14'h0001;

	// ****************************************************************
	// Timing of the link.
	// ****************************************************************
	localparam longint SYS_CLK_HZ   = 100_000_000;
	localparam longint SCLK_MIN_HZ  = 900_000;
	localparam longint SCLK_MAX_HZ  = 4_500_000;
	localparam longint RATE_MIN_SPS = 50_000;
	localparam longint RATE_MAX_SPS = 250_000;

	// Half period of the serial clock in system cycles.
	localparam int HALF_MIN_CYC  = int'((SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ));
	localparam int HALF_MAX_CYC  = int'(SYS_CLK_HZ / (2 * SCLK_MIN_HZ));
	// Distance between two frame starts in system cycles.
	localparam int FRAME_MIN_CYC = int'((SYS_CLK_HZ + RATE_MAX_SPS - 1) / RATE_MAX_SPS);
	localparam int FRAME_MAX_CYC = int'(SYS_CLK_HZ / RATE_MIN_SPS);
	// Chip select stays high at least this many cycles between frames.
	localparam int CS_HIGH_CYC   = 2;

	// ****************************************************************
	// Host sequencer states.
	// ****************************************************************
	typedef enum logic [2:0]
	{
		DSR_IDLE  = 3'h0,
		DSR_SETUP = 3'h1,
		DSR_LOW   = 3'h3,
		DSR_HIGH  = 3'h2,
		DSR_GAP   = 3'h6
	} dsr_state_e;

endpackage : dsr_pkg

// File: dsr_link_if.sv
// Link between the host controller and the converter readout.
`timescale 1ns/1ns
`default_nettype none
interface dsr_link_if;

	logic cs_b;
	logic sclk;
	logic dout;
	logic dout_oe;
	logic dout_line;

	// A released data line is pulled high.
	assign dout_line = dout_oe ? dout : 1'b1;

	modport dev
	(
		input  cs_b,
		input  sclk,
		output dout,
		output dout_oe
	);

	modport host
	(
		output cs_b,
		output sclk,
		input  dout_line
	);

endinterface : dsr_link_if
`default_nettype wire

// File: dsr_dev.sv
// Converter end: acquisition hold, successive approximation and serial output.
//
// Summary of operation
// R1: Result is two's complement of differential input.
// R2: Frame carries its own conversion, no latency.
// R3: Host pulls select low for whole conversion.
// R4: Select high keeps converter tracking input.
// R5: Two null bits, fourteen result bits, MSB first.
// R6: Output changes on falling, host samples rising.
// R7: Serial clock is the only conversion clock.
// R8: Serial clock between 0.9 and 4.5 MHz.
// R9: Frame rate between 50 and 250 kSPS.
// R10: Output released whenever select is high.
`timescale 1ns/1ns
`default_nettype none
module dsr_dev
	import dsr_pkg::*;
(
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst_b,
	input  wire logic [RES_BITS-1:0] i_vin,
	output logic                     o_tracking,
	output logic [RES_BITS-1:0]      o_code,
	output logic                     o_code_valid,
	dsr_link_if.dev                  link
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic                cs_meta_ff;
	logic                cs_sync_ff;
	logic                nxt_cs_meta;
	logic                nxt_cs_sync;
	logic [RES_BITS-1:0] hold_ff;
	logic [RES_BITS-1:0] nxt_hold;
	logic                done_meta_ff;
	logic                done_sync_ff;
	logic                done_seen_ff;
	logic                nxt_done_meta;
	logic                nxt_done_sync;
	logic                nxt_done_seen;
	logic [RES_BITS-1:0] code_ff;
	logic [RES_BITS-1:0] nxt_code;
	logic                code_valid_ff;
	logic                nxt_code_valid;

	logic [CNT_W-1:0]    edge_cnt_ff;
	logic [CNT_W-1:0]    nxt_edge_cnt;
	logic [RES_BITS-1:0] acc_ff;
	logic [RES_BITS-1:0] nxt_acc;
	logic [RES_BITS-1:0] res_ff;
	logic [RES_BITS-1:0] nxt_res;
	logic                dout_ff;
	logic                nxt_dout;
	logic                done_ff;
	logic                nxt_done;

	logic [CNT_W-1:0]    edge_num;
	logic [3:0]          bit_idx;
	logic [RES_BITS-1:0] trial;
	logic [RES_BITS-1:0] off_sample;
	logic                keep;

	// ****************************************************************
	// System domain: select synchroniser and acquisition hold.
	// ****************************************************************
	always_comb
	begin
		nxt_cs_meta = link.cs_b;
		nxt_cs_sync = cs_meta_ff;
		nxt_hold    = hold_ff;
		if (cs_sync_ff)
		begin
			// The hold follows the input while the frame is closed.
			nxt_hold = i_vin; // see R4
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			cs_meta_ff <= 1'b1;
			cs_sync_ff <= 1'b1;
			hold_ff    <= '0;
		end
		else
		begin
			cs_meta_ff <= nxt_cs_meta;
			cs_sync_ff <= nxt_cs_sync;
			hold_ff    <= nxt_hold;
		end
	end

	assign o_tracking = cs_sync_ff; // see R4

	// ****************************************************************
	// System domain: result hand-back from the serial clock domain.
	// ****************************************************************
	always_comb
	begin
		nxt_done_meta  = done_ff;
		nxt_done_sync  = done_meta_ff;
		nxt_done_seen  = done_sync_ff;
		nxt_code       = code_ff;
		nxt_code_valid = 1'b0;
		if (done_sync_ff && !done_seen_ff)
		begin
			// The result word holds until the last step of the next frame.
			nxt_code       = res_ff;
			nxt_code_valid = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			done_meta_ff  <= 1'b0;
			done_sync_ff  <= 1'b0;
			done_seen_ff  <= 1'b0;
			code_ff       <= '0;
			code_valid_ff <= 1'b0;
		end
		else
		begin
			done_meta_ff  <= nxt_done_meta;
			done_sync_ff  <= nxt_done_sync;
			done_seen_ff  <= nxt_done_seen;
			code_ff       <= nxt_code;
			code_valid_ff <= nxt_code_valid;
		end
	end

	assign o_code       = code_ff;
	assign o_code_valid = code_valid_ff;

	// ****************************************************************
	// Link domain: successive approximation on falling serial clock edges.
	// ****************************************************************
	// The hold is frozen from a few system cycles after select falls, well
	// before the third falling edge where the first decision reads it.
	assign off_sample = hold_ff ^ SIGN_MASK; // see R1
	assign edge_num   = edge_cnt_ff + 5'h01;
	assign bit_idx    = 4'(LAST_RES_EDGE - edge_num);
	assign trial      = acc_ff | (ONE_LSB << bit_idx);
	assign keep       = off_sample >= trial;

	always_comb
	begin
		nxt_edge_cnt = edge_cnt_ff;
		nxt_acc      = acc_ff;
		nxt_res      = res_ff;
		nxt_dout     = 1'b0;
		nxt_done     = done_ff;
		if (edge_cnt_ff < FRAME_EDGES)
		begin
			// Each falling edge advances the conversion by one step.
			nxt_edge_cnt = edge_num; // see R7
		end
		if ((edge_num >= FIRST_RES_EDGE) && (edge_num <= LAST_RES_EDGE))
		begin
			// Decide one bit and send it at once, top bit first.
			nxt_acc = keep ? trial : acc_ff; // see R2
			if (bit_idx == 4'(RES_BITS - 1))
			begin
				nxt_dout = ~keep; // see R1
			end
			else
			begin
				nxt_dout = keep; // see R5
			end
		end
		if (edge_num == FRAME_EDGES)
		begin
			nxt_res      = nxt_acc ^ SIGN_MASK; // see R1
			nxt_done     = 1'b1;
		end
	end

	// Select high closes the frame and clears the conversion at once.
	always_ff @(negedge link.sclk or posedge link.cs_b)
	begin
		if (link.cs_b)
		begin
			edge_cnt_ff <= '0;
			acc_ff      <= '0;
			dout_ff     <= 1'b0;
			done_ff     <= 1'b0;
		end
		else
		begin
			edge_cnt_ff <= nxt_edge_cnt;
			acc_ff      <= nxt_acc;
			dout_ff     <= nxt_dout; // see R6
			done_ff     <= nxt_done;
		end
	end

	// The result word outlives the frame.
	always_ff @(negedge link.sclk)
	begin
		res_ff <= nxt_res;
	end

	// ****************************************************************
	// Link pins.
	// ****************************************************************
	// Null bits read as zero: the output register is cleared while the
	// frame is closed and on the first two falling edges.
	assign link.dout    = dout_ff; // see R5
	assign link.dout_oe = ~link.cs_b; // see R10

endmodule : dsr_dev
`default_nettype wire

// File: dsr_link_checker.sv
// Assertions on the link between the host and converter ends.
`timescale 1ns/1ns
`default_nettype none
module dsr_link_checker
	import dsr_pkg::*;
#(
	parameter int HALF_CYC = HALF_MIN_CYC
)
(
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic cs_b,
	input  wire logic sclk,
	input  wire logic dout,
	input  wire logic dout_oe,
	input  wire logic dout_line
);
	logic [11:0] half_ff;
	logic [11:0] nxt_half;
	logic [11:0] gap_ff;
	logic [11:0] nxt_gap;
	logic [4:0]  fall_ff;
	logic [4:0]  nxt_fall;
	logic        sclk_q_ff;
	logic        cs_q_ff;

	// ********
	// Helper counters.
	// ********
	always_comb
	begin
		nxt_half = (sclk != sclk_q_ff) ? 12'h001 : half_ff + 12'h001;
		nxt_fall = cs_b ? 5'h00 : fall_ff + {4'h0, sclk_q_ff & ~sclk};
		nxt_gap  = (cs_q_ff & ~cs_b) ? 12'h001 : gap_ff + {11'h000, gap_ff != 12'hFFF};
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			half_ff   <= 12'h000;
			fall_ff   <= 5'h00;
			gap_ff    <= 12'hFFF;
			sclk_q_ff <= 1'b1;
			cs_q_ff   <= 1'b1;
		end
		else
		begin
			half_ff   <= nxt_half;
			fall_ff   <= nxt_fall;
			gap_ff    <= nxt_gap;
			sclk_q_ff <= sclk;
			cs_q_ff   <= cs_b;
		end
	end

	// ********
	// Assertions.
	// ********
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);

	line_release_a: assert property (cs_b |-> !dout_oe && dout_line)
		else $error("line not released");
	line_drive_a: assert property (!cs_b |-> dout_oe)
		else $error("line not driven");
	null_bits_a: assert property ($fell(cs_b) |-> !dout_line ##1 !dout_line)
		else $error("null bit not low");
	dout_edge_a: assert property (!cs_b && !$past(cs_b) && $changed(dout) |-> $fell(sclk))
		else $error("data moved off falling edge");
	sclk_idle_a: assert property (cs_b |-> sclk)
		else $error("clock not idle");
	clk_setup_a: assert property ($fell(cs_b) |-> sclk [*8])
		else $error("clock too soon after select");
	half_len_a: assert property ($rose(sclk) && !cs_b |-> half_ff == 12'(HALF_CYC))
		else $error("wrong half period");
	edge_count_a: assert property ($rose(cs_b) |-> fall_ff == 5'(FRAME_BITS))
		else $error("wrong edge count");
	frame_space_a: assert property ($fell(cs_b) |-> gap_ff >= 12'(FRAME_MIN_CYC))
		else $error("frames too close");
	cs_gap_a: assert property ($rose(cs_b) |-> cs_b [*2])
		else $error("select high too short");

	start_c: cover property ($fell(cs_b));
	done_c: cover property ($rose(cs_b) && fall_ff == 5'h10);
	one_bit_c: cover property ($fell(sclk) && !cs_b && dout_line);
endmodule : dsr_link_checker
`default_nettype wire

// File: tb.sv
// Self-checking bench joining host and converter ends over the link.
`timescale 1ns/1ns
`default_nettype none
module tb
	import dsr_pkg::*;
;
	typedef struct packed
	{
		logic [13:0] vin;
		logic [15:0] frame;
	} dsr_row_s;

	logic        sys_clk;
	logic        rst_b;
	logic        run;
	logic [13:0] vin;
	logic        tracking;
	logic [13:0] code;
	logic        code_valid;
	logic        busy;
	logic [13:0] data;
	logic        data_valid;
	logic        null_err;
	logic        sclk_q;
	logic        cs_q;
	logic        line_q;
	logic [15:0] wire_sr;
	logic [4:0]  wire_cnt;
	int          num_errors;
	int          n_checks;
	int          cyc;
	int          n_code;
	int          n0;
	dsr_row_s    rows [6];

	dsr_link_if i_dsr_link_if ();

	dsr_dev i_dsr_dev
	(
		.i_sys_clk    (sys_clk),
		.i_rst_b      (rst_b),
		.i_vin        (vin),
		.o_tracking   (tracking),
		.o_code       (code),
		.o_code_valid (code_valid),
		.link         (i_dsr_link_if)
	);

	dsr_host #(.HALF_CYC(HALF_MIN_CYC), .FRAME_CYC(FRAME_MIN_CYC)) i_dsr_host
	(
		.i_sys_clk    (sys_clk),
		.i_rst_b      (rst_b),
		.i_run        (run),
		.o_busy       (busy),
		.o_data       (data),
		.o_data_valid (data_valid),
		.o_null_err   (null_err),
		.link         (i_dsr_link_if)
	);

	dsr_link_checker #(.HALF_CYC(HALF_MIN_CYC)) i_dsr_link_checker
	(
		.i_sys_clk (sys_clk),
		.i_rst_b   (rst_b),
		.cs_b      (i_dsr_link_if.cs_b),
		.sclk      (i_dsr_link_if.sclk),
		.dout      (i_dsr_link_if.dout),
		.dout_oe   (i_dsr_link_if.dout_oe),
		.dout_line (i_dsr_link_if.dout_line)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ********
	// Line monitor: takes the bit on the line at each rising serial clock edge.
	// ********
	always @(posedge sys_clk)
	begin
		sclk_q <= i_dsr_link_if.sclk;
		cs_q   <= i_dsr_link_if.cs_b;
		line_q <= i_dsr_link_if.dout_line;
		n_code <= n_code + int'(code_valid);
		cyc    <= cyc + 1;
		if (cs_q && !i_dsr_link_if.cs_b)
			wire_cnt <= 5'h00;
		else if (!sclk_q && i_dsr_link_if.sclk)
		begin
			wire_sr  <= {wire_sr[14:0], line_q};
			wire_cnt <= wire_cnt + 5'h01;
		end
		if (cyc == 20000)
		begin
			num_errors = num_errors + 1;
			close_out();
		end
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	task automatic wait_data;
		int n;
		n = 0;
		while (data_valid !== 1'b1 && n < 1000)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("wait", 16'(n < 1000), 16'h0001);
	endtask : wait_data

	task automatic frame(input dsr_row_s r);
		@(posedge sys_clk);
		vin <= r.vin;
		repeat (8) @(posedge sys_clk);
		run <= 1'b1;
		while (busy !== 1'b1) @(posedge sys_clk);
		run <= 1'b0;
		repeat (20) @(posedge sys_clk);
		vin <= ~r.vin;
		#1 chk("track", 16'(tracking), 16'h0000);
		wait_data();
		chk("data", {2'b00, data}, {2'b00, r.frame[13:0]});
		chk("code", {2'b00, code}, {2'b00, r.frame[13:0]});
		chk("null", 16'(null_err), 16'h0000);
		chk("wire", wire_sr, r.frame);
		chk("bits", 16'(wire_cnt), 16'h0010);
		repeat (2) @(posedge sys_clk);
		#1 chk("idle", 16'(tracking), 16'h0001);
	endtask : frame

	initial
	begin
		rows = '{'{14'h0000, 16'h0000}, '{14'h0001, 16'h0001}, '{14'h1FFF, 16'h1FFF},
			'{14'h2000, 16'h2000}, '{14'h3FFF, 16'h3FFF}, '{14'h2AD5, 16'h2AD5}};
		{rst_b, run, vin, sclk_q, cs_q, line_q, wire_sr, wire_cnt} = '0;
		{num_errors, n_checks, cyc, n_code} = '0;
		repeat (4) @(posedge sys_clk);
		#1 chk("rst", {12'h000, busy, i_dsr_link_if.cs_b, i_dsr_link_if.dout_line, tracking},
			16'h0007);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (rows[i])
			frame(rows[i]);
		@(posedge sys_clk);
		vin <= 14'h1555;
		repeat (8) @(posedge sys_clk);
		run <= 1'b1;
		wait_data();
		chk("b2b1", {2'b00, data}, 16'h1555);
		@(posedge sys_clk);
		#1 wait_data();
		chk("b2b2", {2'b00, data}, 16'h1555);
		n0 = n_code;
		repeat (100) @(posedge sys_clk);
		rst_b <= 1'b0;
		run <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 chk("abort", {14'h0000, busy, i_dsr_link_if.dout_line}, 16'h0001);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (500) @(posedge sys_clk);
		chk("nores", 16'(n_code - n0), 16'h0000);
		frame(rows[3]);
		close_out();
	end
endmodule : tb
`default_nettype wire
